// ### shared/msf_pkg.sv
// package: constants, types and register map for the motion status flag bank
package msf_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int MAIN_SCAN_US = 100;
    localparam int MAIN_SCAN_CYC = (MAIN_SCAN_US * (CLK_HZ / 1000000) < 1) ? 1 : MAIN_SCAN_US * (CLK_HZ / 1000000);
    localparam logic [15:0] DECEL_CYC_RST = 16'h0010;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_DECEL = 8'h08;
    localparam logic [7:0] OFS_TEST_INFO = 8'h0c;
    localparam logic [7:0] OFS_WDT_CAUSE = 8'h10;
    localparam logic [7:0] OFS_HW_INFO_LO = 8'h14;
    localparam logic [7:0] OFS_HW_INFO_HI = 8'h18;
    localparam logic [7:0] OFS_AMP_MAP = 8'h1c;
    localparam logic [7:0] OFS_FEED = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN = 8'h28;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h2c;

    // ------------------------------------------------------------
    // flag register bit positions
    // ------------------------------------------------------------
    localparam int BIT_READY = 0;
    localparam int BIT_TEST = 1;
    localparam int BIT_FSTOP = 2;
    localparam int BIT_SCOPE = 3;
    localparam int BIT_TEST_ERR = 4;
    localparam int BIT_WDT = 5;
    localparam int BIT_HW_ERR = 6;
    localparam int BIT_SP_ERR = 7;
    localparam int BIT_SERVO_ON = 8;
    localparam int BIT_SERVO_ERR = 9;

    // interrupt event bits
    localparam int EV_READY = 0;
    localparam int EV_TEST_ERR = 1;
    localparam int EV_WDT = 2;
    localparam int EV_FSTOP = 3;
    localparam int EV_SERVO_ERR = 4;
    localparam int EV_N = 5;

    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // readiness sequence states
    typedef enum logic [1:0] {
        RDY_IDLE = 2'b00,
        RDY_CHECK = 2'b01,
        RDY_DONE = 2'b10
    } msf_rdy_e;

    // emergency stop sequence states
    typedef enum logic [1:0] {
        ES_IDLE = 2'b00,
        ES_DECEL = 2'b01,
        ES_HOLD = 2'b10
    } msf_es_e;

    // events the system side reports to the bank
    typedef struct packed {
        logic test_mode;
        logic test_req;
        logic test_refused;
        logic scope_run;
        logic wdt_detect;
        logic [7:0] wdt_cause;
        logic sp_bad;
        logic [31:0] axis_busy;
    } msf_sys_s;

    // results of the checks done outside the bank
    typedef struct packed {
        logic param_ok;
        logic [31:0] axis_used;
        logic [31:0] amp_present;
        logic [5:0] hw_sel_bad;
        logic [47:0] hw_err_detail;
    } msf_chk_s;

endpackage : msf_pkg

// ### rtl/msf_flag_bank.sv
// design: positioning status flag bank with apb registers and interrupt
//
// Contract
// - on ready request rise, check parameters; set ready flag only when no error
// - readiness sequence sends servo parameters to amplifiers and clears m-codes
// - ready flag drops whenever the ready request drops
// - test mode flag high exactly while test mode is in effect
// - refused test mode request sets the test request error flag
// - test request error stores per-axis busy details in one info word
// - forced stop flag is low while external stop input is active
// - forced stop during motion keeps feed advancing and clears servo-on command
// - after decel time the feed value returns to its value at stop start
// - forced stop released before decel time elapses raises a servo error
// - scope running flag is 1 while scope runs, 0 when stopped
// - watchdog detection sets watchdog flag and stores its cause code
// - watchdog error stops all axes at once without a ramp
// - handwheel error flag follows validity of six selects, details recorded
// - servo program error flag high when positioning data is abnormal
// - at reset record per axis amplifier presence for used axes
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module msf_flag_bank
    import msf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic controller_ready_request,
    input wire logic forced_stop_in,
    input wire msf_sys_s sys_in,
    input wire msf_chk_s chk_in,
    input wire logic positioning_active,
    input wire logic [31:0] feed_advance,
    output logic proc_ready_flag,
    output logic servo_param_xfer,
    output logic mcode_clear,
    output logic all_axes_servo_on_cmd,
    output logic immediate_stop,
    output logic [31:0] feed_value,
    output logic irq
);

    // ------------------------------------------------------------
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    logic [2:0] rdy_sync_ff, nxt_rdy_sync;
    logic [2:0] fs_sync_ff, nxt_fs_sync;
    logic rdy_q_ff, nxt_rdy_q;
    logic fs_q_ff, nxt_fs_q;

    always_comb begin
        nxt_rdy_sync = {rdy_sync_ff[1:0], controller_ready_request};
        nxt_fs_sync = {fs_sync_ff[1:0], forced_stop_in};
        nxt_rdy_q = (rdy_sync_ff[1] == rdy_sync_ff[2]) ? rdy_sync_ff[2] : rdy_q_ff;
        nxt_fs_q = (fs_sync_ff[1] == fs_sync_ff[2]) ? fs_sync_ff[2] : fs_q_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_sync_ff <= 3'h0;
            fs_sync_ff <= 3'h0;
            rdy_q_ff <= 1'b0;
            fs_q_ff <= 1'b0;
        end else begin
            rdy_sync_ff <= nxt_rdy_sync;
            fs_sync_ff <= nxt_fs_sync;
            rdy_q_ff <= nxt_rdy_q;
            fs_q_ff <= nxt_fs_q;
        end
    end

    // ------------------------------------------------------------
    // main scan tick and live state
    // ------------------------------------------------------------
    logic [15:0] scan_cnt_ff, nxt_scan_cnt;
    logic scan_tick;
    msf_rdy_e rdy_st_ff, nxt_rdy_st;
    msf_es_e es_st_ff, nxt_es_st;
    logic [15:0] es_cnt_ff, nxt_es_cnt;
    logic [31:0] feed_ff, nxt_feed;
    logic [31:0] feed_snap_ff, nxt_feed_snap;
    logic servo_on_ff, nxt_servo_on;
    logic servo_err_ff, nxt_servo_err;
    logic err_clr_ff, nxt_err_clr;
    logic wdt_live_ff, nxt_wdt_live;
    logic [7:0] wdt_cause_ff, nxt_wdt_cause;
    logic test_err_live_ff, nxt_test_err_live;
    logic [31:0] test_info_ff, nxt_test_info;
    logic [47:0] hw_info_ff, nxt_hw_info;
    logic [31:0] amp_map_ff, nxt_amp_map;
    logic amp_taken_ff, nxt_amp_taken;
    logic ready_live_ff, nxt_ready_live;
    logic [9:0] flags_ff, nxt_flags;
    logic [15:0] decel_ff, nxt_decel;

    assign scan_tick = (scan_cnt_ff == 16'(MAIN_SCAN_CYC - 1));

    // readiness sequence: checks run on the request edge, ready drops at once
    always_comb begin
        nxt_rdy_st = rdy_st_ff;
        nxt_ready_live = ready_live_ff;
        servo_param_xfer = 1'b0;
        mcode_clear = 1'b0;
        case (rdy_st_ff)
            RDY_IDLE: begin
                if (rdy_q_ff) begin
                    nxt_rdy_st = RDY_CHECK;
                end
            end
            RDY_CHECK: begin
                nxt_rdy_st = RDY_DONE;
                if (chk_in.param_ok) begin
                    servo_param_xfer = 1'b1;
                    mcode_clear = 1'b1;
                    nxt_ready_live = 1'b1;
                end
            end
            RDY_DONE: begin
                nxt_rdy_st = RDY_DONE;
            end
            default: begin
                nxt_rdy_st = RDY_IDLE;
            end
        endcase
        if (!rdy_q_ff) begin
            nxt_rdy_st = RDY_IDLE;
            nxt_ready_live = 1'b0;
        end
    end

    // emergency stop: feed keeps moving for the decel time, then snaps back
    always_comb begin
        nxt_es_st = es_st_ff;
        nxt_es_cnt = es_cnt_ff;
        nxt_feed = feed_ff;
        nxt_feed_snap = feed_snap_ff;
        nxt_servo_on = servo_on_ff;
        nxt_servo_err = err_clr_ff ? 1'b0 : servo_err_ff; // a release below still wins
        if (positioning_active && !wdt_live_ff) begin
            nxt_feed = feed_ff + feed_advance;
        end
        case (es_st_ff)
            ES_IDLE: begin
                nxt_servo_on = ready_live_ff;
                if (fs_q_ff && positioning_active) begin
                    nxt_es_st = ES_DECEL;
                    nxt_es_cnt = decel_ff;
                    nxt_feed_snap = feed_ff;
                    nxt_servo_on = 1'b0;
                end else if (fs_q_ff) begin
                    nxt_servo_on = 1'b0;
                end
            end
            ES_DECEL: begin
                nxt_servo_on = 1'b0;
                nxt_feed = feed_ff + feed_advance;
                if (!fs_q_ff) begin
                    nxt_servo_err = 1'b1;
                    nxt_es_st = ES_IDLE;
                end else if (es_cnt_ff <= 16'h0001) begin
                    nxt_feed = feed_snap_ff;
                    nxt_es_st = ES_HOLD;
                end else begin
                    nxt_es_cnt = es_cnt_ff - 16'h0001;
                end
            end
            ES_HOLD: begin
                nxt_servo_on = 1'b0;
                nxt_feed = feed_ff;
                if (!fs_q_ff) begin
                    nxt_es_st = ES_IDLE;
                end
            end
            default: begin
                nxt_es_st = ES_IDLE;
            end
        endcase
        if (wdt_live_ff) begin
            nxt_feed = feed_ff;
            nxt_servo_on = 1'b0;
        end
    end

    // capture of error details, presence map and watchdog cause
    always_comb begin
        nxt_scan_cnt = scan_tick ? 16'h0000 : scan_cnt_ff + 16'h0001;
        nxt_wdt_live = wdt_live_ff;
        nxt_wdt_cause = wdt_cause_ff;
        nxt_test_err_live = test_err_live_ff;
        nxt_test_info = test_info_ff;
        nxt_hw_info = hw_info_ff;
        nxt_amp_map = amp_map_ff;
        nxt_amp_taken = 1'b1;
        if (!amp_taken_ff) begin
            nxt_amp_map = chk_in.axis_used & chk_in.amp_present;
        end
        if (sys_in.wdt_detect && !wdt_live_ff) begin
            nxt_wdt_live = 1'b1;
            nxt_wdt_cause = sys_in.wdt_cause;
        end
        if (sys_in.test_req) begin
            nxt_test_err_live = sys_in.test_refused;
            if (sys_in.test_refused) begin
                nxt_test_info = sys_in.axis_busy;
            end
        end
        if (|chk_in.hw_sel_bad) begin
            nxt_hw_info = chk_in.hw_err_detail;
        end
    end

    // published flags refresh on the scan tick so a read is coherent; the ready bit clears at once
    always_comb begin
        nxt_flags = flags_ff;
        if (scan_tick) begin
            nxt_flags[BIT_READY] = ready_live_ff;
            nxt_flags[BIT_TEST] = sys_in.test_mode;
            nxt_flags[BIT_FSTOP] = ~fs_q_ff;
            nxt_flags[BIT_SCOPE] = sys_in.scope_run;
            nxt_flags[BIT_TEST_ERR] = test_err_live_ff;
            nxt_flags[BIT_WDT] = wdt_live_ff;
            nxt_flags[BIT_HW_ERR] = |chk_in.hw_sel_bad;
            nxt_flags[BIT_SP_ERR] = sys_in.sp_bad;
            nxt_flags[BIT_SERVO_ON] = servo_on_ff;
            nxt_flags[BIT_SERVO_ERR] = servo_err_ff;
        end
        if (!ready_live_ff) begin
            nxt_flags[BIT_READY] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb slave and interrupt registers
    // ------------------------------------------------------------
    logic [EV_N-1:0] irq_stat_ff, nxt_irq_stat;
    logic [EV_N-1:0] irq_en_ff, nxt_irq_en;
    logic [EV_N-1:0] events;
    logic [31:0] prdata_ff, nxt_prdata;
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // true for every mapped register word
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= OFS_IRQ_CLR);
    endfunction : is_mapped

    assign addr_ok = is_mapped(paddr);

    assign events[EV_READY] = ready_live_ff && !flags_ff[BIT_READY] && scan_tick;
    assign events[EV_TEST_ERR] = nxt_test_err_live && !test_err_live_ff;
    assign events[EV_WDT] = nxt_wdt_live && !wdt_live_ff;
    assign events[EV_FSTOP] = nxt_es_st == ES_DECEL && es_st_ff != ES_DECEL;
    assign events[EV_SERVO_ERR] = nxt_servo_err && !servo_err_ff;

    // register writes; a new event beats a clear in the same cycle
    always_comb begin
        nxt_irq_en = irq_en_ff;
        nxt_decel = decel_ff;
        nxt_err_clr = 1'b0;
        nxt_irq_stat = irq_stat_ff;
        if (wr_acc && paddr == OFS_IRQ_EN) begin
            nxt_irq_en = pwdata[EV_N-1:0];
        end
        if (wr_acc && paddr == OFS_DECEL) begin
            nxt_decel = pwdata[15:0];
        end
        if (wr_acc && paddr == OFS_CTRL) begin
            nxt_err_clr = pwdata[0];
        end
        if (wr_acc && paddr == OFS_IRQ_CLR) begin
            nxt_irq_stat = irq_stat_ff & ~pwdata[EV_N-1:0];
        end
        nxt_irq_stat = nxt_irq_stat | events;
    end

    // read mux, captured in setup so data stands from the access phase
    always_comb begin
        nxt_prdata = prdata_ff;
        if (rd_acc) begin
            case (paddr)
                OFS_FLAGS: nxt_prdata = {22'h0, flags_ff};
                OFS_DECEL: nxt_prdata = {16'h0, decel_ff};
                OFS_TEST_INFO: nxt_prdata = test_info_ff;
                OFS_WDT_CAUSE: nxt_prdata = {24'h0, wdt_cause_ff};
                OFS_HW_INFO_LO: nxt_prdata = hw_info_ff[31:0];
                OFS_HW_INFO_HI: nxt_prdata = {16'h0, hw_info_ff[47:32]};
                OFS_AMP_MAP: nxt_prdata = amp_map_ff;
                OFS_FEED: nxt_prdata = feed_ff;
                OFS_IRQ_STAT: nxt_prdata = {27'h0, irq_stat_ff};
                OFS_IRQ_EN: nxt_prdata = {27'h0, irq_en_ff};
                default: nxt_prdata = RD_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt_ff <= 16'h0000;
            rdy_st_ff <= RDY_IDLE;
            es_st_ff <= ES_IDLE;
            es_cnt_ff <= 16'h0000;
            feed_ff <= 32'h0000_0000;
            feed_snap_ff <= 32'h0000_0000;
            servo_on_ff <= 1'b0;
            servo_err_ff <= 1'b0;
            wdt_live_ff <= 1'b0;
            wdt_cause_ff <= 8'h00;
            test_err_live_ff <= 1'b0;
            test_info_ff <= 32'h0000_0000;
            hw_info_ff <= 48'h0000_0000_0000;
            amp_map_ff <= 32'h0000_0000;
            amp_taken_ff <= 1'b0;
            ready_live_ff <= 1'b0;
            flags_ff <= 10'h000;
            decel_ff <= DECEL_CYC_RST;
            irq_stat_ff <= 5'h00;
            irq_en_ff <= 5'h00;
            prdata_ff <= 32'h0000_0000;
            err_clr_ff <= 1'b0;
        end else begin
            scan_cnt_ff <= nxt_scan_cnt;
            rdy_st_ff <= nxt_rdy_st;
            es_st_ff <= nxt_es_st;
            es_cnt_ff <= nxt_es_cnt;
            feed_ff <= nxt_feed;
            feed_snap_ff <= nxt_feed_snap;
            servo_on_ff <= nxt_servo_on;
            servo_err_ff <= nxt_servo_err;
            wdt_live_ff <= nxt_wdt_live;
            wdt_cause_ff <= nxt_wdt_cause;
            test_err_live_ff <= nxt_test_err_live;
            test_info_ff <= nxt_test_info;
            hw_info_ff <= nxt_hw_info;
            amp_map_ff <= nxt_amp_map;
            amp_taken_ff <= nxt_amp_taken;
            ready_live_ff <= nxt_ready_live;
            flags_ff <= nxt_flags;
            decel_ff <= nxt_decel;
            irq_stat_ff <= nxt_irq_stat;
            irq_en_ff <= nxt_irq_en;
            prdata_ff <= nxt_prdata;
            err_clr_ff <= nxt_err_clr;
        end
    end

    // outputs
    assign prdata = prdata_ff;
    assign proc_ready_flag = flags_ff[BIT_READY];
    assign all_axes_servo_on_cmd = servo_on_ff;
    assign immediate_stop = wdt_live_ff;
    assign feed_value = feed_ff;
    assign irq = |(irq_stat_ff & irq_en_ff);

endmodule : msf_flag_bank

// ### tb/msf_flag_bank_props.sv
// checker: port-level properties of the status flag bank
`timescale 1ns/1ns
module msf_flag_bank_props
    import msf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic controller_ready_request,
    input wire logic forced_stop_in,
    input wire msf_sys_s sys_in,
    input wire msf_chk_s chk_in,
    input wire logic positioning_active,
    input wire logic [31:0] feed_advance,
    input wire logic proc_ready_flag,
    input wire logic servo_param_xfer,
    input wire logic mcode_clear,
    input wire logic all_axes_servo_on_cmd,
    input wire logic immediate_stop,
    input wire logic [31:0] feed_value,
    input wire logic irq
);
    // ------------------------------------------------------------
    // properties, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rdy_gate_a: assert property ($rose(proc_ready_flag) |-> controller_ready_request)
        else $error("ready flag rose without a request");
    xfer_ok_a: assert property (servo_param_xfer |-> chk_in.param_ok)
        else $error("parameter transfer after a failed check");
    xfer_pair_a: assert property (servo_param_xfer == mcode_clear)
        else $error("transfer and code clear out of step");
    rdy_drop_a: assert property (!controller_ready_request [*8] |-> !proc_ready_flag)
        else $error("ready flag stays up without request");
    // watchdog input has no sync stages; one register step gives the stop its bound
    wdt_stop_a: assert property (sys_in.wdt_detect |-> ##[1:3] immediate_stop)
        else $error("no immediate stop after watchdog");
    stop_hold_a: assert property (immediate_stop |=> immediate_stop)
        else $error("immediate stop released before reset");
    servo_off_a: assert property ((forced_stop_in && positioning_active) [*8] |-> !all_axes_servo_on_cmd)
        else $error("servo on kept during forced stop");
    feed_adv_a: assert property ((!forced_stop_in [*8] ##0 (positioning_active && !immediate_stop
        && !sys_in.wdt_detect)) |=> feed_value == $past(feed_value) + $past(feed_advance))
        else $error("feed value did not advance");
    err_resp_a: assert property (psel && penable |-> pslverr == (paddr > 8'h2c || paddr[1:0] != 2'b00))
        else $error("error response wrong for address");

    cover property ($rose(proc_ready_flag));
    cover property ($rose(immediate_stop));
    cover property ($fell(all_axes_servo_on_cmd));
endmodule : msf_flag_bank_props

bind msf_flag_bank msf_flag_bank_props u_props (.*);

// ### tb/msf_plc_model.sv
// partner: host processor that raises the ready request and resets on watchdog
`timescale 1ns/1ns
module msf_plc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic want_ready,
    input wire logic [3:0] lag,
    input wire logic immediate_stop,
    output logic controller_ready_request,
    output logic sys_reset_req
);
    // ------------------------------------------------------------
    // request follows the wish after a chosen lag, so answers can be slow
    // ------------------------------------------------------------
    logic [3:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 4'h0;
            controller_ready_request <= 1'b0;
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= immediate_stop;
            if (want_ready == controller_ready_request) begin
                cnt_ff <= 4'h0;
            end else if (cnt_ff >= lag) begin
                controller_ready_request <= want_ready;
                cnt_ff <= 4'h0;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule : msf_plc_model

// ### tb/msf_flag_bank_tb_top.sv
// testbench: drives the status flag bank over apb and its status pins
`timescale 1ns/1ns
module msf_flag_bank_tb_top
    import msf_pkg::*;
;
    typedef struct {logic [31:0] exp; logic [31:0] msk; logic err;} msf_exp_s;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, feed_advance = 32'h0, prdata, feed_value, snap, r;
    logic pready, pslverr, forced_stop_in = 1'b0, positioning_active = 1'b0;
    logic want_ready = 1'b0, controller_ready_request, sys_reset_req;
    logic proc_ready_flag, servo_param_xfer, mcode_clear, all_axes_servo_on_cmd, immediate_stop, irq;
    logic [3:0] lag = 4'h0;
    msf_sys_s sys_in = '0;
    msf_chk_s chk_in = '0;
    msf_exp_s exp_q[$];
    msf_exp_s mon_e;
    int failures = 0, num_checks = 0, i;

    always #25 pclk = ~pclk;
    msf_flag_bank uut (.*);
    msf_plc_model plc (.*);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // flags publish once per main scan; wait one plus sync slack
    task scan;
        cyc(MAIN_SCAN_CYC + 20);
    endtask : scan
    task rst;
        presetn <= 1'b0;
        cyc(6);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : rst
    // one transfer; an extra edge keeps two requests from sharing a time step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back('{e & m, m, (a > 8'h2c || a[1:0] != 2'b00)});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task end_sim;
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // read monitor: each finished read is matched with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            chk("prdata", mon_e.exp, prdata & mon_e.msk);
            chk("pslverr", {31'h0, mon_e.err}, {31'h0, pslverr});
        end
    end

    // watchdog against a hung run
    initial begin
        cyc(70000);
        failures++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        r = $urandom(32'h9e59);
        chk_in.axis_used <= $urandom();
        chk_in.amp_present <= $urandom();
        rst();
        rd(OFS_AMP_MAP, chk_in.axis_used & chk_in.amp_present, ALL);
        rd(OFS_DECEL, {16'h0, DECEL_CYC_RST}, ALL);
        rd(8'h30, 32'h0, ALL);
        rd(8'h02, 32'h0, ALL);
        apb(1'b1, OFS_DECEL, 32'h0000_0014);
        rd(OFS_DECEL, 32'h0000_0014, 32'h0000_ffff);
        // ready request with a failed check, then a passing one
        lag <= 4'($urandom_range(0, 9));
        want_ready <= 1'b1;
        scan();
        rd(OFS_FLAGS, 32'h0, 32'h1);
        want_ready <= 1'b0;
        cyc(20);
        chk_in.param_ok <= 1'b1;
        want_ready <= 1'b1;
        for (i = 0; i < 40 && servo_param_xfer !== 1'b1; i++) @(posedge pclk);
        chk("param transfer", 32'h1, {31'h0, servo_param_xfer});
        chk("code clear", 32'h1, {31'h0, mcode_clear});
        scan();
        chk("ready flag", 32'h1, {31'h0, proc_ready_flag});
        rd(OFS_IRQ_STAT, 32'h1, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_IRQ_EN, 32'h1f);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_IRQ_CLR, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        want_ready <= 1'b0;
        cyc(20);
        chk("ready dropped", 32'h0, {31'h0, proc_ready_flag});
        rd(OFS_FLAGS, 32'h0, 32'h1);
        // random status pins against the published flag word
        for (i = 0; i < 6; i++) begin
            r = $urandom();
            sys_in.test_mode <= r[0];
            sys_in.scope_run <= r[1];
            sys_in.sp_bad <= r[2];
            chk_in.hw_sel_bad <= r[8:3] & {6{r[9]}};
            chk_in.hw_err_detail <= {r[31:16], r};
            forced_stop_in <= r[10];
            scan();
            rd(OFS_FLAGS, {24'h0, r[2], |(r[8:3] & {6{r[9]}}), 2'b00, r[1], !r[10], r[0], 1'b0}, 32'hce);
            if (r[9] && r[8:3] != 6'h00) begin
                rd(OFS_HW_INFO_LO, r, ALL);
                rd(OFS_HW_INFO_HI, {16'h0, r[31:16]}, 32'h0000_ffff);
            end
        end
        forced_stop_in <= 1'b0;
        // ready comes back so the forced stop below has a servo-on to drop
        want_ready <= 1'b1;
        // refused test request records busy axes, an accepted one clears
        for (i = 0; i < 2; i++) begin
            r = $urandom();
            sys_in.axis_busy <= r;
            sys_in.test_req <= 1'b1;
            sys_in.test_refused <= (i == 0);
            @(posedge pclk);
            sys_in.test_req <= 1'b0;
            scan();
            rd(OFS_FLAGS, (i == 0) ? 32'h10 : 32'h0, 32'h10);
            if (i == 0) rd(OFS_TEST_INFO, r, ALL);
        end
        // forced stop in motion: feed runs on, servo drops, feed snaps back
        r = $urandom_range(1, 255);
        snap = r * 10;
        feed_advance <= r;
        positioning_active <= 1'b1;
        cyc(10);
        feed_advance <= 32'h0;
        cyc(2);
        chk("servo on before stop", 32'h1, {31'h0, all_axes_servo_on_cmd});
        forced_stop_in <= 1'b1;
        cyc(8);
        feed_advance <= 32'h5;
        cyc(4);
        chk("feed advancing", 32'h1, {31'h0, feed_value != snap});
        chk("servo on cmd", 32'h0, {31'h0, all_axes_servo_on_cmd});
        feed_advance <= 32'h0;
        cyc(30);
        chk("feed restored", snap, feed_value);
        rd(OFS_FEED, snap, ALL);
        forced_stop_in <= 1'b0;
        scan();
        rd(OFS_FLAGS, 32'h0, 32'h200);
        forced_stop_in <= 1'b1;
        cyc(12);
        forced_stop_in <= 1'b0;
        scan();
        rd(OFS_FLAGS, 32'h200, 32'h200);
        rd(OFS_IRQ_STAT, 32'h18, 32'h18);
        apb(1'b1, OFS_CTRL, 32'h1);
        scan();
        rd(OFS_FLAGS, 32'h0, 32'h200);
        // watchdog stops at once; the host answers with a full reset
        r = $urandom();
        sys_in.wdt_cause <= r[7:0];
        sys_in.wdt_detect <= 1'b1;
        @(posedge pclk);
        sys_in.wdt_detect <= 1'b0;
        scan();
        rd(OFS_FLAGS, 32'h20, 32'h20);
        rd(OFS_WDT_CAUSE, {24'h0, r[7:0]}, 32'h0000_00ff);
        chk("immediate stop", 32'h1, {31'h0, immediate_stop});
        for (i = 0; i < 10 && sys_reset_req !== 1'b1; i++) @(posedge pclk);
        chk_in.amp_present <= $urandom();
        rst();
        rd(OFS_AMP_MAP, chk_in.axis_used & chk_in.amp_present, ALL);
        scan();
        rd(OFS_FLAGS, 32'h0, 32'h20);
        end_sim();
    end
endmodule : msf_flag_bank_tb_top
